// File: verilog/amcs_pkg.sv
package amcs_pkg;

    localparam int APB_AW = 8;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL     = 8'h00;
    localparam logic [7:0] OFS_CONFIG   = 8'h04;
    localparam logic [7:0] OFS_STATUS   = 8'h08;
    localparam logic [7:0] OFS_DATA     = 8'h0c;
    localparam logic [7:0] OFS_INT_STAT = 8'h10;
    localparam logic [7:0] OFS_INT_MASK = 8'h14;
    localparam logic [7:0] OFS_OFS_COEF = 8'h18;
    localparam logic [7:0] OFS_FS_COEF  = 8'h1c;

    // Control register fields
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_RATE_LSB = 4;
    localparam logic [3:0] RATE_RESET = 4'ha;

    // Configuration register fields
    localparam int CFG_CH_LSB    = 0;
    localparam int CFG_GAIN_LSB  = 8;
    localparam int CFG_EXC_BIT   = 16;
    localparam int CFG_BURN_BIT  = 17;
    localparam int CFG_BIAS_BIT  = 18;
    localparam int CFG_CLKO_BIT  = 19;
    localparam logic [19:0] CFG_RESET = 20'h00000;
    localparam logic [2:0]  GAIN_UNITY = 3'h0;
    localparam logic [2:0]  GAIN_128   = 3'h7;

    // Status register fields
    localparam int STAT_RDY_BIT   = 0;
    localparam int STAT_STATE_LSB = 4;
    localparam int STAT_MODE_LSB  = 8;

    // Interrupt bits
    localparam int INT_W       = 3;
    localparam int INT_CONV    = 0;
    localparam int INT_CAL     = 1;
    localparam int INT_REFUSED = 2;

    // Timing
    localparam int CLK_HZ       = 100_000_000;
    localparam int US_PER_S     = 1_000_000;
    localparam int US_PER_MS    = 1000;
    localparam int CHZ_PER_HZ   = 100;
    localparam int US_CYCLES    = CLK_HZ / US_PER_S;
    localparam int OSC_START_MS = 1;
    localparam int TIMER_W      = 20;
    localparam logic [TIMER_W-1:0] OSC_START_US = TIMER_W'(OSC_START_MS * US_PER_MS);
    localparam logic [2:0] CAL_CYC_SHORT = 3'h2;
    localparam logic [2:0] CAL_CYC_LONG  = 3'h4;

    typedef enum logic [2:0] {
        MD_CONT   = 3'b000,
        MD_SINGLE = 3'b001,
        MD_IDLE   = 3'b010,
        MD_PWRDN  = 3'b011,
        MD_INT_ZS = 3'b100,
        MD_INT_FS = 3'b101,
        MD_SYS_ZS = 3'b110,
        MD_SYS_FS = 3'b111
    } amcs_mode_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_PWRDN = 3'b001,
        ST_WAKE  = 3'b010,
        ST_CONV  = 3'b011,
        ST_CAL   = 3'b100
    } amcs_state_t;

    // Output rate in hundredths of a hertz; code 0 is undefined, run it slowest
    function automatic int rate_chz(input int code);
        case (code)
            1: return 47000;
            2: return 24200;
            3: return 12300;
            4: return 6200;
            5: return 5000;
            6: return 3900;
            7: return 3320;
            8: return 1960;
            9: return 1670;
            10: return 1670;
            11: return 1250;
            12: return 1000;
            13: return 833;
            14: return 625;
            default: return 417;
        endcase
    endfunction

    function automatic int settle_ms(input int code);
        case (code)
            1: return 4;
            2: return 8;
            3: return 16;
            4: return 32;
            5: return 40;
            6: return 48;
            7: return 60;
            8: return 101;
            9: return 120;
            10: return 120;
            11: return 160;
            12: return 200;
            13: return 240;
            14: return 320;
            default: return 480;
        endcase
    endfunction

endpackage

// File: verilog/amcs_coef_mem.sv
`timescale 1ns/1ns
module amcs_coef_mem #(
    parameter int DW = 24,
    parameter int AW = 4
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [DW-1:0] wr_data,
    input  wire logic [AW-1:0] rd_addr,
    output logic      [DW-1:0] rd_data
);
    // Coefficient array is not reset, like any RAM
    logic [DW-1:0] mem [2**AW];

    always_ff @(posedge pclk)
    begin
        if (wr_en)
        begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rd_data <= '0;
        end
        else
        begin
            rd_data <= mem[rd_addr];
        end
    end
endmodule

// File: verilog/amcs_sequencer.sv
// Function
// - After single conversion keep result, ready low until read or next conversion.
// - Idle mode holds filter and modulator in reset, modulator clock still runs.
// - Power-down disables excitation, burnout, bias and clock output driver.
// - Internal zero-scale: short selected input, finish in 2 conversion cycles.
// - Every calibration raises ready indicator at start, lowers it at end.
// - Any finished calibration switches operating mode to idle.
// - Zero-scale calibrations store offset coefficient of the selected channel.
// - Full-scale calibrations store full-scale coefficient of the selected channel.
// - Internal full-scale: apply full scale, 2 cycles unity gain, else 4.
// - Internal full-scale at gain 128 is refused; host uses system calibration.
// - System zero-scale measures external zero on selected channel, 2 cycles.
// - System full-scale measures external full scale on selected channel, 2 cycles.
// - Rate codes 1..7 give 470..33.2 Hz, settling 4..60 ms; code 0 undefined.
// - Rate codes 8..15 give 19.6..4.17 Hz, settling 101..480 ms.
// - Continuous conversion is the mode after reset.
// - Single conversion waits 1 ms for oscillator start before converting.
//
// Register access over APB and the register offsets were decided locally.
`timescale 1ns/1ns
module amcs_sequencer
    import amcs_pkg::*;
#(
    parameter int DW            = 24,
    parameter int CH_W          = 3,
    parameter int US_TICK_CYCLES = US_CYCLES
) (
    input  wire logic                       pclk,
    input  wire logic                       presetn,
    input  wire logic                       psel,
    input  wire logic                       penable,
    input  wire logic                       pwrite,
    input  wire logic [amcs_pkg::APB_AW-1:0] paddr,
    input  wire logic [31:0]                pwdata,
    output logic      [31:0]                prdata,
    output logic                            pready,
    output logic                            pslverr,
    input  wire logic [DW-1:0]              sample_data,
    output logic                            rdy_n,
    output logic                            filter_reset,
    output logic                            mod_clk_en,
    output logic                            analog_en,
    output logic                            excitation_en,
    output logic                            burnout_en,
    output logic                            bias_en,
    output logic                            clock_output_driver,
    output logic                            cal_short_en,
    output logic                            cal_fs_ref_en,
    output logic [CH_W-1:0]                 channel_select,
    output logic [2:0]                      gain_select,
    output logic                            irq
);
    import amcs_pkg::*;

    // Per-code timing, built from constants so no runtime divider is needed
    logic [TIMER_W-1:0] period_tab [16];
    logic [TIMER_W-1:0] settle_tab [16];

    for (genvar g = 0; g < 16; g++)
    begin : g_rate
        assign period_tab[g] = TIMER_W'(CHZ_PER_HZ * US_PER_S / rate_chz(g));
        assign settle_tab[g] = TIMER_W'(settle_ms(g) * US_PER_MS);
    end

    // Microsecond time base
    logic [15:0] pre_reg;
    logic [15:0] pre_next;
    logic        tick;

    assign tick = (pre_reg == 16'(US_TICK_CYCLES - 1));

    always_comb
    begin
        pre_next = tick ? 16'h0000 : pre_reg + 16'h0001;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pre_reg <= 16'h0000;
        end
        else
        begin
            pre_reg <= pre_next;
        end
    end

    // APB decode
    logic apb_setup;
    logic apb_access;
    logic wr_acc;
    logic rd_acc;
    logic mapped;

    assign apb_setup  = psel && !penable;
    assign apb_access = psel && penable;
    assign wr_acc     = apb_access && pwrite && mapped;
    assign rd_acc     = apb_access && !pwrite && mapped;
    assign pready     = 1'b1;
    assign pslverr    = apb_access && !mapped;

    always_comb
    begin
        case (paddr)
            OFS_CTRL, OFS_CONFIG, OFS_STATUS, OFS_DATA,
            OFS_INT_STAT, OFS_INT_MASK, OFS_OFS_COEF, OFS_FS_COEF: mapped = 1'b1;
            default: mapped = 1'b0;
        endcase
    end

    // Software registers
    logic [3:0]       rate_reg;
    logic [3:0]       rate_next;
    logic [19:0]      cfg_reg;
    logic [19:0]      cfg_next;
    logic [INT_W-1:0] mask_reg;
    logic [INT_W-1:0] mask_next;
    logic [INT_W-1:0] istat_reg;
    logic [INT_W-1:0] istat_next;
    logic [INT_W-1:0] events;
    logic [2:0]       gain;

    assign gain           = cfg_reg[CFG_GAIN_LSB +: 3];
    assign channel_select = cfg_reg[CFG_CH_LSB +: CH_W];
    assign gain_select    = gain;

    always_comb
    begin
        rate_next  = rate_reg;
        cfg_next   = cfg_reg;
        mask_next  = mask_reg;
        istat_next = istat_reg;
        if (wr_acc && paddr == OFS_CTRL)
        begin
            rate_next = pwdata[CTRL_RATE_LSB +: 4];
        end
        if (wr_acc && paddr == OFS_CONFIG)
        begin
            cfg_next = pwdata[19:0];
        end
        if (wr_acc && paddr == OFS_INT_MASK)
        begin
            mask_next = pwdata[INT_W-1:0];
        end
        if (wr_acc && paddr == OFS_INT_STAT)
        begin
            istat_next = istat_reg & ~pwdata[INT_W-1:0];
        end
        // A new event beats a clear in the same cycle
        istat_next = istat_next | events;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rate_reg  <= RATE_RESET;
            cfg_reg   <= CFG_RESET;
            mask_reg  <= '0;
            istat_reg <= '0;
        end
        else
        begin
            rate_reg  <= rate_next;
            cfg_reg   <= cfg_next;
            mask_reg  <= mask_next;
            istat_reg <= istat_next;
        end
    end

    assign irq = |(istat_reg & mask_reg);

    // Sequencer
    amcs_mode_t         mode_reg;
    amcs_mode_t         mode_next;
    amcs_state_t        state_reg;
    amcs_state_t        state_next;
    logic [TIMER_W-1:0] timer_reg;
    logic [TIMER_W-1:0] timer_next;
    logic [2:0]         ncyc_reg;
    logic [2:0]         ncyc_next;
    logic               rdy_n_reg;
    logic               rdy_n_next;
    logic [DW-1:0]      data_reg;
    logic [DW-1:0]      data_next;
    logic               coef_we;
    logic               expire;
    amcs_mode_t         wr_mode;

    assign expire  = tick && (timer_reg == TIMER_W'(1));
    assign wr_mode = amcs_mode_t'(pwdata[CTRL_MODE_LSB +: 3]);

    always_comb
    begin
        mode_next  = mode_reg;
        state_next = state_reg;
        timer_next = timer_reg;
        ncyc_next  = ncyc_reg;
        rdy_n_next = rdy_n_reg;
        data_next  = data_reg;
        coef_we    = 1'b0;
        events     = '0;
        if (rd_acc && paddr == OFS_DATA)
        begin
            rdy_n_next = 1'b1;
        end
        if (tick && timer_reg > TIMER_W'(1))
        begin
            timer_next = timer_reg - TIMER_W'(1);
        end
        if (wr_acc && paddr == OFS_CTRL)
        begin
            // A mode write aborts whatever sequence was running
            mode_next = wr_mode;
            ncyc_next = CAL_CYC_SHORT;
            timer_next = period_tab[pwdata[CTRL_RATE_LSB +: 4]];
            case (wr_mode)
                MD_CONT:
                begin
                    state_next = ST_CONV;
                    timer_next = settle_tab[pwdata[CTRL_RATE_LSB +: 4]];
                end
                MD_SINGLE:
                begin
                    state_next = ST_WAKE;
                    timer_next = OSC_START_US;
                end
                MD_IDLE: state_next = ST_IDLE;
                MD_PWRDN: state_next = ST_PWRDN;
                MD_INT_FS:
                begin
                    if (gain == GAIN_128)
                    begin
                        // Refused: no coefficient is touched
                        mode_next = MD_IDLE;
                        state_next = ST_IDLE;
                        events[INT_REFUSED] = 1'b1;
                    end
                    else
                    begin
                        state_next = ST_CAL;
                        rdy_n_next = 1'b1;
                        ncyc_next = (gain == GAIN_UNITY) ? CAL_CYC_SHORT : CAL_CYC_LONG;
                    end
                end
                default:
                begin
                    state_next = ST_CAL;
                    rdy_n_next = 1'b1;
                end
            endcase
        end
        else if (expire)
        begin
            case (state_reg)
                ST_WAKE:
                begin
                    state_next = ST_CONV;
                    timer_next = settle_tab[rate_reg];
                end
                ST_CONV:
                begin
                    data_next = sample_data;
                    rdy_n_next = 1'b0;
                    events[INT_CONV] = 1'b1;
                    if (mode_reg == MD_SINGLE)
                    begin
                        // Result stays put while powered down; ready stays low until a data read
                        mode_next = MD_PWRDN;
                        state_next = ST_PWRDN;
                    end
                    else
                    begin
                        timer_next = period_tab[rate_reg];
                    end
                end
                ST_CAL:
                begin
                    if (ncyc_reg <= 3'h1)
                    begin
                        coef_we = 1'b1;
                        rdy_n_next = 1'b0;
                        mode_next = MD_IDLE;
                        state_next = ST_IDLE;
                        events[INT_CAL] = 1'b1;
                    end
                    else
                    begin
                        ncyc_next = ncyc_reg - 3'h1;
                        timer_next = period_tab[rate_reg];
                    end
                end
                default: state_next = state_reg;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            mode_reg  <= MD_CONT;
            state_reg <= ST_CONV;
            timer_reg <= TIMER_W'(settle_ms(int'(RATE_RESET)) * US_PER_MS);
            ncyc_reg  <= CAL_CYC_SHORT;
            rdy_n_reg <= 1'b1;
            data_reg  <= '0;
        end
        else
        begin
            mode_reg  <= mode_next;
            state_reg <= state_next;
            timer_reg <= timer_next;
            ncyc_reg  <= ncyc_next;
            rdy_n_reg <= rdy_n_next;
            data_reg  <= data_next;
        end
    end

    assign rdy_n = rdy_n_reg;

    // Analog and clock controls decoded from the sequencer state
    logic pwr_on;

    assign pwr_on              = (state_reg != ST_PWRDN);
    assign analog_en           = pwr_on;
    assign excitation_en       = pwr_on && cfg_reg[CFG_EXC_BIT];
    assign burnout_en          = pwr_on && cfg_reg[CFG_BURN_BIT];
    assign bias_en             = pwr_on && cfg_reg[CFG_BIAS_BIT];
    assign clock_output_driver = pwr_on && cfg_reg[CFG_CLKO_BIT];
    assign mod_clk_en          = pwr_on;
    // Waking oscillator has nothing valid to filter yet
    assign filter_reset        = (state_reg == ST_IDLE) || !pwr_on
                                 || (state_reg == ST_WAKE);
    assign cal_short_en        = (state_reg == ST_CAL) && (mode_reg == MD_INT_ZS);
    assign cal_fs_ref_en       = (state_reg == ST_CAL) && (mode_reg == MD_INT_FS);

    // Coefficients, one offset and one full-scale word per channel
    logic [CH_W:0]  coef_wr_addr;
    logic [CH_W:0]  coef_rd_addr;
    logic [DW-1:0]  coef_q;
    logic           fs_mode;

    // Mode bit 0 tells full-scale from zero-scale among calibrations
    assign fs_mode      = mode_reg[0];
    assign coef_wr_addr = {fs_mode, channel_select};
    assign coef_rd_addr = {(paddr == OFS_FS_COEF), channel_select};

    amcs_coef_mem #(
        .DW (DW),
        .AW (CH_W + 1)
    ) u_coef (
        .pclk    (pclk),
        .presetn (presetn),
        .wr_en   (coef_we),
        .wr_addr (coef_wr_addr),
        .wr_data (sample_data),
        .rd_addr (coef_rd_addr),
        .rd_data (coef_q)
    );

    // Read data is captured in the setup cycle and shown during access
    logic [31:0] rd_reg;
    logic [31:0] rd_next;
    logic        coef_sel_reg;
    logic        coef_sel_next;

    always_comb
    begin
        rd_next       = rd_reg;
        coef_sel_next = coef_sel_reg;
        if (apb_setup)
        begin
            coef_sel_next = (paddr == OFS_OFS_COEF) || (paddr == OFS_FS_COEF);
            case (paddr)
                OFS_CTRL:
                    rd_next = {24'h000000, rate_reg, 1'b0, mode_reg};
                OFS_CONFIG:
                    rd_next = {12'h000, cfg_reg};
                OFS_STATUS:
                    rd_next = {20'h00000, 1'b0, mode_reg, 1'b0, state_reg, 3'h0, rdy_n_reg};
                OFS_DATA:
                    rd_next = 32'(data_reg);
                OFS_INT_STAT:
                    rd_next = 32'(istat_reg);
                OFS_INT_MASK:
                    rd_next = 32'(mask_reg);
                default:
                    rd_next = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rd_reg       <= 32'h00000000;
            coef_sel_reg <= 1'b0;
        end
        else
        begin
            rd_reg       <= rd_next;
            coef_sel_reg <= coef_sel_next;
        end
    end

    assign prdata = coef_sel_reg ? 32'(coef_q) : rd_reg;

endmodule

// File: tb/amcs_seq_chk.sv
`timescale 1ns/1ns
module amcs_seq_chk
    import amcs_pkg::*;
#(
    parameter int US_TICK_CYCLES = US_CYCLES
) (
    input wire logic       pclk,
    input wire logic       presetn,
    input wire logic       psel,
    input wire logic       penable,
    input wire logic       pwrite,
    input wire logic [31:0] prdata,
    input wire logic       pready,
    input wire logic       pslverr,
    input wire logic       rdy_n,
    input wire logic       filter_reset,
    input wire logic       mod_clk_en,
    input wire logic       analog_en,
    input wire logic       excitation_en,
    input wire logic       burnout_en,
    input wire logic       bias_en,
    input wire logic       clock_output_driver,
    input wire logic       cal_short_en,
    input wire logic       cal_fs_ref_en,
    input wire logic [2:0] gain_select
);
    // Fastest rate gives the shortest calibration; one tick of slack
    localparam int CAL_MIN = (2 * 2127 - 1) * US_TICK_CYCLES;
    localparam int FS4_MIN = (4 * 2127 - 1) * US_TICK_CYCLES;
    logic [19:0] run_reg;
    logic [19:0] run_next;
    logic        wr_now;
    assign wr_now = psel && penable && pwrite;
    always_comb
    begin
        run_next = (cal_short_en || cal_fs_ref_en) ? run_reg + 20'h1 : 20'h0;
    end
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            run_reg <= 20'h0;
        else
            run_reg <= run_next;
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // A mode write may abort a calibration, so only undisturbed ends count
    sequence s_cal_done;
        $fell(cal_short_en || cal_fs_ref_en) && !$past(wr_now);
    endsequence
    AST_PD_OFF: assert property (!mod_clk_en |-> filter_reset && !(analog_en || excitation_en
        || burnout_en || bias_en || clock_output_driver)) else $error("power-down left on");
    AST_IDLE_CLK: assert property (s_cal_done |-> filter_reset && mod_clk_en && analog_en)
        else $error("not idle after calibration");
    AST_CAL_RDY: assert property ((cal_short_en || cal_fs_ref_en) |-> rdy_n)
        else $error("ready low during calibration");
    AST_CAL_END: assert property (s_cal_done |-> !rdy_n) else $error("ready not low at end");
    AST_NO_OVERLAP: assert property (cal_short_en |-> !cal_fs_ref_en)
        else $error("short and full-scale together");
    AST_G128: assert property ($rose(cal_fs_ref_en) |-> gain_select != GAIN_128)
        else $error("internal full-scale at top gain");
    AST_CAL_MIN: assert property (s_cal_done |-> run_reg >= CAL_MIN)
        else $error("calibration too short");
    AST_FS4_MIN: assert property (s_cal_done ##0 ($past(cal_fs_ref_en)
        && gain_select != GAIN_UNITY) |-> run_reg >= FS4_MIN) else $error("full-scale too short");
    AST_SLVERR: assert property (pslverr |-> psel && penable && prdata == 32'h0)
        else $error("bad error response");
    AST_PREADY: assert property (psel && penable |-> pready) else $error("no ready");
endmodule
bind amcs_sequencer amcs_seq_chk #(.US_TICK_CYCLES(US_TICK_CYCLES)) u_chk (.*);

// File: tb/amcs_adc_model.sv
`timescale 1ns/1ns
module amcs_adc_model #(
    parameter int DW = 24
) (
    input wire logic          pclk,
    input wire logic          analog_en,
    input wire logic [DW-1:0] level,
    output logic     [DW-1:0] sample_data
);
    logic [DW-1:0] churn = '0;
    always @(posedge pclk)
    begin
        churn <= churn + 1'b1;
    end
    // A powered-down front end yields no stable value
    assign sample_data = analog_en ? level : ~level ^ churn;
endmodule

// File: tb/amcs_sequencer_tb_top.sv
`timescale 1ns/1ns
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
    $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module amcs_sequencer_tb_top;
    import amcs_pkg::*;
    logic        pclk = 1'b0;
    logic        presetn, psel, penable, pwrite, pready, pslverr, rdy_n, irq;
    logic        filter_reset, mod_clk_en, analog_en, excitation_en, burnout_en;
    logic        bias_en, clock_output_driver, cal_short_en, cal_fs_ref_en, err_q;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd_q;
    logic [23:0] sample_data, lvl;
    logic [2:0]  channel_select, gain_select;
    int          num_errors = 0;
    int          n_tests = 0;
    amcs_mode_t  t_md [5] = '{MD_INT_ZS, MD_SYS_ZS, MD_SYS_FS, MD_INT_FS, MD_INT_FS};
    int          t_code [5] = '{1, 2, 3, 1, 1};
    logic [2:0]  t_gain [5] = '{3'h0, 3'h0, 3'h7, 3'h0, 3'h3};
    int          t_ncyc [5] = '{2, 2, 2, 2, 4};
    int          chz [3] = '{47000, 24200, 12300};
    amcs_sequencer #(.US_TICK_CYCLES(1)) dut (.*);
    amcs_adc_model #(.DW(24)) u_adc (.pclk(pclk), .analog_en(analog_en), .level(lvl),
        .sample_data(sample_data));
    always #5 pclk = ~pclk;
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr_en;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Request stands until the edge that sees pready; answer taken there
        do
        begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd_q    = prdata;
        err_q   = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK("read", e, rd_q & m)
    endtask
    task automatic wait_low(input int exp_n);
        int n;
        n = 1;
        while (rdy_n !== 1'b0 && n < 40000)
        begin
            @(negedge pclk);
            n++;
        end
        `CHK("duration", 1'b1, (n >= exp_n - 3) && (n <= exp_n + 5))
    endtask
    task automatic cal_run(input amcs_mode_t md, input int code, input int exp_n);
        wr(OFS_CTRL, {24'h0, 4'(code), 1'b0, md});
        @(negedge pclk);
        `CHK("ready at start", 1'b1, rdy_n)
        wait_low(exp_n);
        `CHK("idle outputs", 2'b11, {filter_reset, mod_clk_en})
    endtask
    initial
    begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        lvl = 24'h0;
        presetn = 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(OFS_CTRL, 32'hf7, 32'ha0);
        rdchk(OFS_STATUS, 32'h771, 32'h031);
        rdchk(OFS_INT_MASK, 32'h7, 32'h0);
        apb(1'b0, 8'h20, 32'h0);
        `CHK("unmapped error", 1'b1, err_q)
        `CHK("unmapped data", 32'h0, rd_q)
        wr(OFS_INT_MASK, 32'h6);
        for (int i = 0; i < 5; i++)
        begin
            wr(OFS_CONFIG, {21'h0, t_gain[i], 5'h0, 3'(i + 1)});
            lvl <= 24'h5a0000 + 24'(i);
            cal_run(t_md[i], t_code[i], t_ncyc[i] * (100000000 / chz[t_code[i] - 1]) + 1);
            `CHK("irq raised", 1'b1, irq)
            rdchk(OFS_CTRL, 32'h7, {29'h0, MD_IDLE});
            rdchk(t_md[i][0] ? OFS_FS_COEF : OFS_OFS_COEF, 32'hffffff, 32'h5a0000 + i);
            wr(OFS_INT_STAT, 32'h2);
            @(negedge pclk);
            `CHK("irq cleared", 1'b0, irq)
        end
        wr(OFS_CONFIG, {21'h0, GAIN_128, 8'h0});
        wr(OFS_CTRL, {24'h0, 4'h1, 1'b0, MD_INT_FS});
        rdchk(OFS_CTRL, 32'h7, {29'h0, MD_IDLE});
        rdchk(OFS_INT_STAT, 32'h7, 32'h4);
        `CHK("ready kept", 1'b0, rdy_n)
        `CHK("irq refused", 1'b1, irq)
        wr(OFS_INT_MASK, 32'h0);
        @(negedge pclk);
        `CHK("irq masked", 1'b0, irq)
        wr(OFS_INT_STAT, 32'h4);
        wr(OFS_CONFIG, 32'h000f0001);
        rdchk(OFS_OFS_COEF, 32'hffffff, 32'h5a0000);
        wr(OFS_CTRL, {24'h0, 4'h1, 1'b0, MD_IDLE});
        @(negedge pclk);
        `CHK("idle enables", 7'h7f, {filter_reset, mod_clk_en, analog_en, excitation_en,
            burnout_en, bias_en, clock_output_driver})
        wr(OFS_CTRL, {24'h0, 4'h1, 1'b0, MD_PWRDN});
        @(negedge pclk);
        `CHK("down enables", 7'h40, {filter_reset, mod_clk_en, analog_en, excitation_en,
            burnout_en, bias_en, clock_output_driver})
        apb(1'b0, OFS_DATA, 32'h0);
        lvl <= 24'h3c3c3c;
        wr(OFS_CTRL, {24'h0, 4'h1, 1'b0, MD_SINGLE});
        @(negedge pclk);
        wait_low(1000 + 4000 + 1);
        repeat (20) @(negedge pclk);
        `CHK("result held", 1'b0, rdy_n)
        rdchk(OFS_CTRL, 32'h7, {29'h0, MD_PWRDN});
        rdchk(OFS_DATA, 32'hffffff, 32'h3c3c3c);
        @(negedge pclk);
        `CHK("ready after read", 1'b1, rdy_n)
        close_out();
    end
    initial
    begin
        repeat (90000) @(posedge pclk);
        num_errors++;
        close_out();
    end
endmodule
